// >>> hdl/ohcc_pkg.sv
// ohcc_pkg: constants shared by the clock-control upper byte block
// assumes: 32-bit AXI4-Lite register bus, 25 MHz single clock
`default_nettype none
package ohcc_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] MASK_ADDR   = 8'h08;
  localparam logic [7:0] STATE_ADDR  = 8'h0C;
  // control field positions in clock_control
  localparam int BIT_RST_SEL   = 15;
  localparam int BIT_XTAL_OFF  = 14;
  localparam int BIT_EXT_OFF   = 13;
  localparam int BIT_WD_HALTI  = 12;
  localparam int BIT_OSC2_HALTI = 11;
  localparam int BIT_OSC2_OFF  = 10;
  localparam int BIT_OSC1_HALTI = 9;
  localparam int BIT_OSC1_OFF  = 8;
  localparam int CTRL_LSB      = 8;
  localparam int CTRL_MSB      = 15;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // status event bits
  localparam int EV_CLK_FAIL   = 0;
  localparam int EV_MCLK_RST   = 1;
  localparam int EV_W          = 2;
  localparam logic [1:0] EV_RESET = 2'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> hdl/ohcc_sync_if.sv
// ohcc_sync_if: carries the raw asynchronous event levels and their synchronised copies
// assumes: the synchroniser drives sync, the top reads it
`default_nettype none
interface ohcc_sync_if;
  logic [2:0] raw;
  logic [2:0] sync;
  modport syncer (input raw, output sync);
  modport user   (output raw, input sync);
endinterface
`default_nettype wire

// >>> hdl/ohcc_sync.sv
// ohcc_sync: two-flop synchronisers for the pin-level status inputs
// assumes: clk is the register-bus clock, synchronous active-low reset
`default_nettype none
module ohcc_sync (
  // clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // levels to synchronise
  ohcc_sync_if.syncer   sif
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;

  // first stage read only by the second stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end
    else
    begin
      meta_r <= sif.raw;
      sync_r <= meta_r;
    end
  end

  assign sif.sync = sync_r;
endmodule
`default_nettype wire

// >>> hdl/ohcc_top.sv
// ohcc_top: upper byte of the clock control register, halt gating and missing-clock reset routing
// assumes: AXI4-Lite master on clk, detector/halt/nmi inputs asynchronous to clk
// What this block does
// - select 0 gives missing-clock reset at once
// - select 1 routes reset via NMI watchdog reset
// - clock-fail flag on every detected missing clock
// - bit 14 switches crystal oscillator off
// - bit 13 disables external clock input
// - bit 12 zero stops watchdog in halt
// - bit 12 one keeps watchdog through halt
// - bit 11 zero stops oscillator 2 in halt
// - bit 11 one keeps oscillator 2 in halt
// - bit 10 switches oscillator 2 off
// - detector never overrides oscillator 2 off
// - bit 9 zero stops oscillator 1 in halt
// - bit 9 one keeps oscillator 1 in halt
// - bit 8 zero keeps oscillator 1 running unless halted with bit 9 zero
// - bit 8 one stops oscillator 1, no override
`default_nettype none
module ohcc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // asynchronous system inputs
  input  wire logic        missing_clk_detect,
  input  wire logic        halt_mode,
  input  wire logic        nmi_watchdog_reset,
  // oscillator and clock controls
  output var  logic        crystal_osc_off,
  output var  logic        ext_clk_input_off,
  output var  logic        osc1_off,
  output var  logic        osc2_off,
  output var  logic        wdog_clock_en,
  // missing-clock outcomes
  output var  logic        clock_fail_flag,
  output var  logic        missing_clk_reset,
  // interrupt
  output var  logic        irq
);
  // synchronised inputs
  ohcc_sync_if sif ();
  logic missing_s;
  logic halt_s;
  logic nmi_s;

  assign sif.raw = {nmi_watchdog_reset, halt_mode, missing_clk_detect};
  assign missing_s = sif.sync[0];
  assign halt_s    = sif.sync[1];
  assign nmi_s     = sif.sync[2];

  ohcc_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .sif   (sif.syncer)
  );

  // registers
  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [1:0]  status_r;
  logic [1:0]  status_nxt;
  logic [1:0]  mask_r;
  logic [1:0]  mask_nxt;
  logic        missing_d_r;

  // write channel latches so address and data may come in either order
  logic [7:0]  aw_addr_r;
  logic        aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_have_r;

  // write handshakes and decode
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic wr_known;
  logic lane1;
  logic lane0;
  logic [7:0] lane1_data;
  logic [7:0] lane0_data;

  assign aw_take    = s_axi_awvalid && s_axi_awready;
  assign w_take     = s_axi_wvalid && s_axi_wready;
  assign wr_fire    = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_ctrl    = wr_fire && (aw_addr_r == ohcc_pkg::CTRL_ADDR);
  assign wr_status  = wr_fire && (aw_addr_r == ohcc_pkg::STATUS_ADDR);
  assign wr_mask    = wr_fire && (aw_addr_r == ohcc_pkg::MASK_ADDR);
  assign wr_known   = wr_ctrl || wr_status || wr_mask || (aw_addr_r == ohcc_pkg::STATE_ADDR);
  assign lane1      = w_strb_r[1];
  assign lane0      = w_strb_r[0];
  assign lane1_data = w_data_r[ohcc_pkg::CTRL_MSB:ohcc_pkg::CTRL_LSB];
  assign lane0_data = w_data_r[7:0];

  // control byte, only written with byte lane 1
  assign ctrl_nxt = (wr_ctrl && lane1) ? lane1_data : ctrl_r;

  // missing-clock event edge, one pulse per detection
  logic miss_rise;
  logic reset_cause;
  assign miss_rise = missing_s && !missing_d_r;

  // reset path selected by bit 15
  assign reset_cause = ctrl_r[ohcc_pkg::BIT_RST_SEL - ohcc_pkg::CTRL_LSB]
                       ? nmi_s
                       : missing_s;

  // sticky status: a set in the same cycle as a write-one clear wins
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  assign ev_set     = {reset_cause && !missing_clk_reset, miss_rise};
  assign ev_clr     = (wr_status && lane0) ? lane0_data[ohcc_pkg::EV_W-1:0] : 2'h0;
  assign status_nxt = (status_r & ~ev_clr) | ev_set;
  assign mask_nxt   = (wr_mask && lane0) ? lane0_data[ohcc_pkg::EV_W-1:0] : mask_r;

  // register state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_r      <= ohcc_pkg::CTRL_RESET;
      status_r    <= ohcc_pkg::EV_RESET;
      mask_r      <= ohcc_pkg::EV_RESET;
      missing_d_r <= 1'b0;
    end
    else
    begin
      ctrl_r      <= ctrl_nxt;
      status_r    <= status_nxt;
      mask_r      <= mask_nxt;
      missing_d_r <= missing_s;
    end
  end

  // gated controls: halt forces off only when the ignore bit is clear
  logic xtal_nxt;
  logic ext_nxt;
  logic osc1_nxt;
  logic osc2_nxt;
  logic wdog_nxt;
  assign xtal_nxt = ctrl_r[ohcc_pkg::BIT_XTAL_OFF - ohcc_pkg::CTRL_LSB];
  assign ext_nxt  = ctrl_r[ohcc_pkg::BIT_EXT_OFF - ohcc_pkg::CTRL_LSB];
  // the detector input is deliberately absent from both off terms
  assign osc2_nxt = ctrl_r[ohcc_pkg::BIT_OSC2_OFF - ohcc_pkg::CTRL_LSB]
                    || (halt_s && !ctrl_r[ohcc_pkg::BIT_OSC2_HALTI - ohcc_pkg::CTRL_LSB]);
  assign osc1_nxt = ctrl_r[ohcc_pkg::BIT_OSC1_OFF - ohcc_pkg::CTRL_LSB]
                    || (halt_s && !ctrl_r[ohcc_pkg::BIT_OSC1_HALTI - ohcc_pkg::CTRL_LSB]);
  assign wdog_nxt = !halt_s || ctrl_r[ohcc_pkg::BIT_WD_HALTI - ohcc_pkg::CTRL_LSB];

  // outputs registered so pins never glitch on decode changes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      crystal_osc_off   <= 1'b0;
      ext_clk_input_off <= 1'b0;
      osc1_off          <= 1'b0;
      osc2_off          <= 1'b0;
      wdog_clock_en     <= 1'b1;
      clock_fail_flag   <= 1'b0;
      missing_clk_reset <= 1'b0;
      irq               <= 1'b0;
    end
    else
    begin
      crystal_osc_off   <= xtal_nxt;
      ext_clk_input_off <= ext_nxt;
      osc1_off          <= osc1_nxt;
      osc2_off          <= osc2_nxt;
      wdog_clock_en     <= wdog_nxt;
      clock_fail_flag   <= missing_s;
      missing_clk_reset <= reset_cause;
      irq               <= |(status_nxt & mask_nxt);
    end
  end

  // write path: accept each channel once, answer after both are held
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ohcc_pkg::RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= ohcc_pkg::ZERO_WORD;
      w_strb_r      <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !aw_have_r && !aw_take && !s_axi_bvalid;
      s_axi_wready  <= !w_have_r && !w_take && !s_axi_bvalid;
      if (aw_take)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
      end
      if (w_take)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
      end
      if (wr_fire)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? ohcc_pkg::RESP_OKAY : ohcc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode
  logic        ar_take;
  logic [31:0] rd_word;
  logic        rd_known;
  logic [31:0] state_word;
  assign ar_take    = s_axi_arvalid && s_axi_arready;
  assign state_word = {24'h00_0000, 3'h0, missing_clk_reset, clock_fail_flag,
                       wdog_clock_en, osc2_off, osc1_off};
  assign rd_known   = (s_axi_araddr == ohcc_pkg::CTRL_ADDR) || (s_axi_araddr == ohcc_pkg::STATUS_ADDR)
                      || (s_axi_araddr == ohcc_pkg::MASK_ADDR) || (s_axi_araddr == ohcc_pkg::STATE_ADDR);
  assign rd_word    = (s_axi_araddr == ohcc_pkg::CTRL_ADDR)   ? {16'h0000, ctrl_r, 8'h00} :
                      (s_axi_araddr == ohcc_pkg::STATUS_ADDR) ? {30'h0000_0000, status_r} :
                      (s_axi_araddr == ohcc_pkg::MASK_ADDR)   ? {30'h0000_0000, mask_r} :
                      (s_axi_araddr == ohcc_pkg::STATE_ADDR)  ? state_word : ohcc_pkg::ZERO_WORD;

  // read path: one read at a time, data one cycle after the address is taken
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= ohcc_pkg::ZERO_WORD;
      s_axi_rresp   <= ohcc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? ohcc_pkg::RESP_OKAY : ohcc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/ohcc_checker.sv
// ohcc_checker: bus and missing-clock timing checks on the top ports
// assumes: bound onto ohcc_top, one clock, synchronous active-low reset
`default_nettype none
module ohcc_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // system levels and outcomes
  input wire logic        missing_clk_detect,
  input wire logic        nmi_watchdog_reset,
  input wire logic        halt_mode,
  input wire logic        wdog_clock_en,
  input wire logic        clock_fail_flag,
  input wire logic        missing_clk_reset
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // both write channels taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // a level held long enough to cross two sync flops and the output flop
  sequence s_det_held;
    missing_clk_detect [*4];
  endsequence

  AST_WR_LAT: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // the flag tracks the detector whatever the reset routing says
  AST_FAIL_SET: assert property (s_det_held |-> clock_fail_flag)
    else $error("clock fail flag missing");
  AST_FAIL_CLR: assert property ((!missing_clk_detect) [*4] |-> !clock_fail_flag)
    else $error("clock fail flag stuck");
  AST_RST_BOTH: assert property ((missing_clk_detect && nmi_watchdog_reset) [*4] |-> missing_clk_reset)
    else $error("missing clock reset absent");
  AST_RST_CAUSE: assert property (missing_clk_reset |-> $past(missing_clk_detect, 3) || $past(nmi_watchdog_reset, 3))
    else $error("missing clock reset without cause");
  AST_WDOG_RUN: assert property ((!halt_mode) [*4] |-> wdog_clock_en)
    else $error("watchdog clock stopped outside halt");
endmodule

bind ohcc_top ohcc_checker ohcc_chk_u (
  .clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .missing_clk_detect, .nmi_watchdog_reset, .halt_mode, .wdog_clock_en, .clock_fail_flag, .missing_clk_reset
);
`default_nettype wire

// >>> verification/ohcc_tb.sv
// tb: self-checking bench for the clock-control upper byte
// assumes: ohcc_top as AXI4-Lite slave, 25 MHz clock, no partner model
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        missing_clk_detect, halt_mode, nmi_watchdog_reset, irq;
  logic        crystal_osc_off, ext_clk_input_off, osc1_off, osc2_off, wdog_clock_en;
  logic        clock_fail_flag, missing_clk_reset;
  int          failures, n_tests, i;
  // expected outputs with only control bit 8..15 set, no halt, no detector
  logic [7:0]  exp_b [8] = '{8'h18, 8'h08, 8'h28, 8'h08, 8'h08, 8'h48, 8'h88, 8'h08};
  // all non-bus outputs packed so one compare sees every control pin
  wire logic [7:0] outs = {crystal_osc_off, ext_clk_input_off, osc2_off, osc1_off,
                           wdog_clock_en, clock_fail_flag, missing_clk_reset, irq};

  ohcc_top dut_u (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .missing_clk_detect, .halt_mode, .nmi_watchdog_reset, .crystal_osc_off,
    .ext_clk_input_off, .osc1_off, .osc2_off, .wdog_clock_en, .clock_fail_flag, .missing_clk_reset, .irq);

  // free-running 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test;
    begin
      $display("compares %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        failures++;
        $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask

  // a wait that runs out ends the run as a mismatch
  task automatic give_up(input int n);
    begin
      if (n == 40)
      begin
        failures++;
        stop_test;
      end
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
        @(posedge clk);
        if (s_axi_awready === 1'b1)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1)
          break;
      end
      s_axi_bready <= 1'b0;
      rsp = s_axi_bresp;
      give_up(n);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    begin
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
        @(posedge clk);
        if (s_axi_arready === 1'b1)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1)
          break;
      end
      s_axi_rready <= 1'b0;
      rd_v = s_axi_rdata;
      rsp  = s_axi_rresp;
      give_up(n);
    end
  endtask

  // main sequence; waits of five edges cover the three-edge pin latency
  initial
  begin
    failures = 0;
    n_tests  = 0;
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {missing_clk_detect, halt_mode, nmi_watchdog_reset} = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h0000_0000;
    s_axi_wstrb  = 4'hF;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(ohcc_pkg::CTRL_ADDR);
    chk(rd_v, ohcc_pkg::ZERO_WORD);
    for (i = 8; i < 16; i++)
    begin
      wr(ohcc_pkg::CTRL_ADDR, 32'h0000_0001 << i);
      rd(ohcc_pkg::CTRL_ADDR);
      chk(rd_v, 32'h0000_0001 << i);
      repeat (2) @(posedge clk);
      chk({24'h0, outs}, {24'h0, exp_b[i-8]});
    end
    $display("test control bits done");
    wr(ohcc_pkg::CTRL_ADDR, 32'h0000_0000);
    halt_mode <= 1'b1;
    repeat (5) @(posedge clk);
    chk({24'h0, outs}, 32'h0000_0030);
    wr(ohcc_pkg::CTRL_ADDR, 32'h0000_1A00);
    repeat (3) @(posedge clk);
    chk({24'h0, outs}, 32'h0000_0008);
    wr(ohcc_pkg::CTRL_ADDR, 32'h0000_0500);
    missing_clk_detect <= 1'b1;
    repeat (5) @(posedge clk);
    chk({24'h0, outs}, 32'h0000_0036);
    rd(ohcc_pkg::STATUS_ADDR);
    chk(rd_v, 32'h0000_0003);
    wr(ohcc_pkg::MASK_ADDR, 32'h0000_0003);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    missing_clk_detect <= 1'b0;
    halt_mode <= 1'b0;
    repeat (5) @(posedge clk);
    wr(ohcc_pkg::STATUS_ADDR, 32'h0000_0003);
    rd(ohcc_pkg::STATUS_ADDR);
    chk(rd_v, ohcc_pkg::ZERO_WORD);
    chk({24'h0, outs}, 32'h0000_0038);
    $display("test halt and direct reset done");
    wr(ohcc_pkg::CTRL_ADDR, 32'h0000_8000);
    missing_clk_detect <= 1'b1;
    repeat (5) @(posedge clk);
    chk({24'h0, outs}, 32'h0000_000D);
    nmi_watchdog_reset <= 1'b1;
    repeat (5) @(posedge clk);
    chk({24'h0, outs}, 32'h0000_000F);
    $display("test watchdog reset routing done");
    wr(8'h10, 32'h0000_FFFF);
    chk({30'h0, rsp}, {30'h0, ohcc_pkg::RESP_SLVERR});
    rd(8'h10);
    chk({30'h0, rsp}, {30'h0, ohcc_pkg::RESP_SLVERR});
    rd(ohcc_pkg::CTRL_ADDR);
    chk(rd_v, 32'h0000_8000);
    $display("test unmapped access done");
    // running from the external input: crystal forced off, input left on
    missing_clk_detect <= 1'b0;
    nmi_watchdog_reset <= 1'b0;
    wr(ohcc_pkg::CTRL_ADDR, 32'h0000_4000);
    repeat (5) @(posedge clk);
    chk({24'h0, outs}, 32'h0000_0089);
    // a reset in mid-run must clear the control byte and every output except wdog_clock_en, which reset sets to one
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(ohcc_pkg::CTRL_ADDR);
    chk(rd_v, ohcc_pkg::ZERO_WORD);
    chk({24'h0, outs}, 32'h0000_0008);
    $display("test external input and mid-run reset done");
    stop_test;
  end
endmodule
`default_nettype wire
